// file: design/wdcs_pkg.sv
/*
 * Shared constants and types of the watchdog with clear window and control synchroniser.
 * Assumes one core clock at 10 MHz and a watchdog source derived from it by a divider.
 */
package wdcs_pkg;

   // Register port geometry.
   localparam int          ADDR_W    = 4;
   localparam int          DATA_W    = 32;

   // Register offsets, byte addresses of aligned words.
   localparam logic [3:0]  OFS_CTRL  = 4'h0;
   localparam logic [3:0]  OFS_CLEAR = 4'h4;
   localparam logic [3:0]  OFS_COUNT = 4'h8;

   // Field positions in the control word.
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_MODE_BIT = 1;
   localparam int          CTRL_TO_LSB   = 8;
   localparam int          CTRL_BAN_LSB  = 16;
   localparam int          SEL_W         = 5;
   localparam int          CLEAR_BIT     = 0;

   // Largest timeout select that still fits the 32-bit counter.
   localparam logic [4:0]  TO_SEL_MAX    = 5'h1E;

   // Timing: core clock and selected watchdog clock source.
   localparam int          CORE_PERIOD_NS   = 100;
   localparam int          WD_SRC_PERIOD_NS = 1000;
   localparam int          WD_DIV = (WD_SRC_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

   // Least wait of a control update, in bus cycles and in watchdog cycles.
   localparam logic [1:0]  SYNC_BUS_CYCLES = 2'h2;
   localparam logic [1:0]  SYNC_WD_CYCLES  = 2'h2;

   // Control fields that cross into the watchdog domain.
   typedef struct packed {
      logic [4:0] ban_prescale_select;
      logic [4:0] timeout_prescale;
      logic       mode;
      logic       enable;
   } wdcs_ctrl_t;

   localparam wdcs_ctrl_t CTRL_RESET = 12'h000;

   // Counter states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_COUNT,
      ST_FIRED
   } wdcs_state_t;

endpackage

// file: design/wdcs_tick_gen.sv
/*
 * Divider that makes the watchdog clock tick as a one-cycle strobe.
 * Assumes DIV is at least two; the tick stands one core cycle in every DIV.
 */
`timescale 1ns/1ps
module wdcs_tick_gen
   import wdcs_pkg::*;
#(
   parameter int DIV = WD_DIV
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   output logic      o_tick
);

   localparam int            CW   = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          tick_reg;
   logic          tick_next;

   // The count wraps at the last value, and the tick marks the wrap.
   always_comb begin
      cnt_next  = (cnt_reg == LAST) ? '0 : CW'(cnt_reg + 1'b1);
      tick_next = (cnt_reg == LAST);
   end

   // Registers of the divider.
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign o_tick = tick_reg;

endmodule

// file: design/wdcs_ctrl_sync.sv
/*
 * Carries a new control word into the watchdog clock domain.
 * Assumes loads arrive only while not busy; the top refuses any other.
 */
`timescale 1ns/1ps
module wdcs_ctrl_sync
   import wdcs_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_load,
   input  wire wdcs_ctrl_t i_data,
   input  wire logic       i_wd_tick,
   output wdcs_ctrl_t      o_q,
   output wdcs_ctrl_t      o_hold,
   output logic            o_busy
);

   wdcs_ctrl_t hold_reg;
   wdcs_ctrl_t hold_next;
   wdcs_ctrl_t q_reg;
   wdcs_ctrl_t q_next;
   logic       busy_reg;
   logic       busy_next;
   logic [1:0] bc_reg;
   logic [1:0] bc_next;
   logic [1:0] wc_reg;
   logic [1:0] wc_next;

   // Both waits run side by side; the word lands once both have run out.
   always_comb begin
      hold_next = hold_reg;
      q_next    = q_reg;
      busy_next = busy_reg;
      bc_next   = bc_reg;
      wc_next   = wc_reg;
      if (i_load) begin
         hold_next = i_data; // RL4
         busy_next = 1'b1;
         bc_next   = 2'h0;
         wc_next   = 2'h0;
      end else if (busy_reg) begin
         if (bc_reg != SYNC_BUS_CYCLES) begin
            bc_next = 2'(bc_reg + 2'h1);
         end
         if (i_wd_tick && (wc_reg != SYNC_WD_CYCLES)) begin
            wc_next = 2'(wc_reg + 2'h1);
         end
         if ((bc_reg == SYNC_BUS_CYCLES) && (wc_reg == SYNC_WD_CYCLES)) begin
            q_next    = hold_reg; // RL4
            busy_next = 1'b0;
         end
      end
   end

   // Registers of the synchroniser.
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         hold_reg <= CTRL_RESET;
         q_reg    <= CTRL_RESET;
         busy_reg <= 1'b0;
         bc_reg   <= 2'h0;
         wc_reg   <= 2'h0;
      end else begin
         hold_reg <= hold_next;
         q_reg    <= q_next;
         busy_reg <= busy_next;
         bc_reg   <= bc_next;
         wc_reg   <= wc_next;
      end
   end

   assign o_q    = q_reg;
   assign o_hold = hold_reg;
   assign o_busy = busy_reg;

   sync_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL4
      i_load |=> o_busy [*2])
      else $error("Control update finished in under two bus cycles.");

   sync_land_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL4
      (o_busy && !i_load && bc_reg == SYNC_BUS_CYCLES && wc_reg == SYNC_WD_CYCLES)
      |=> (!o_busy && o_q == $past(hold_reg)))
      else $error("Control word did not land when both waits ran out.");

   sync_steady_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL5
      (o_busy ##1 o_busy) |-> $stable(o_q))
      else $error("Active control changed while the update was in flight.");

endmodule

// file: design/wdcs_top.sv
/*
 * Watchdog counter with a clear window, behind a plain register port.
 * Control writes travel through a synchroniser into the watchdog clock,
 * which is a tick derived from the core clock. The register master holds
 * the port signals synchronous to i_core_clk and never waits.
 */
// How it works
// RL1 - Clear in second half of timeout fires watchdog reset at once.
// RL2 - Clear in first half restarts the count without any reset; in window mode the code fires on a clear below the ban count.
// RL3 - Uncleared counter fires reset only after the whole timeout period.
// RL4 - Writing control fields starts a synchroniser into the watchdog domain.
// RL5 - Enable readback shows the old value until the new one acts.
// RL6 - Software polls the enable bit until it matches what it wrote.
// RL7 - Software waits two bus and two watchdog cycles between control writes.
// RL8 - Timeout is the watchdog clock scaled by prescale; half marks boundary.
`timescale 1ns/1ps
module wdcs_top
   import wdcs_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   output logic                   o_wd_reset,
   output logic                   o_active
);

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog clock and control synchroniser.

   logic        wd_tick;
   logic        ctrl_wr;
   logic        clr_wr;
   logic        sync_busy;
   wdcs_ctrl_t  ctrl_new;
   wdcs_ctrl_t  act;
   wdcs_ctrl_t  hold;

   wdcs_tick_gen #(
      .DIV (WD_DIV)
   ) u_tick (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .o_tick     (wd_tick)
   );

   // A control write in flight refuses the next one; overlapping writes are
   // undefined on the real part, so dropping them is the safest reading.
   assign ctrl_wr = i_wr && (i_addr == OFS_CTRL) && !sync_busy; // RL7
   assign clr_wr  = i_wr && (i_addr == OFS_CLEAR) && i_wdata[CLEAR_BIT];

   // Field extraction of the written control word.
   assign ctrl_new.enable              = i_wdata[CTRL_EN_BIT];
   assign ctrl_new.mode                = i_wdata[CTRL_MODE_BIT];
   assign ctrl_new.timeout_prescale    = i_wdata[CTRL_TO_LSB +: SEL_W];
   assign ctrl_new.ban_prescale_select = i_wdata[CTRL_BAN_LSB +: SEL_W];

   wdcs_ctrl_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_load     (ctrl_wr), // RL4
      .i_data     (ctrl_new),
      .i_wd_tick  (wd_tick),
      .o_q        (act),
      .o_hold     (hold),
      .o_busy     (sync_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Timeout geometry from the active control.

   logic [4:0]  to_sel;
   logic [4:0]  ban_sel;
   logic [31:0] period;
   logic [31:0] half;
   logic [31:0] ban;

   // Selects are clamped so the period still fits the counter; a larger timeout
   // select than the maximum behaves as the maximum, and a ban select larger than the timeout select behaves as the timeout select.
   always_comb begin
      to_sel  = (act.timeout_prescale > TO_SEL_MAX) ? TO_SEL_MAX : act.timeout_prescale;
      ban_sel = (act.ban_prescale_select > to_sel) ? to_sel : act.ban_prescale_select;
      period  = 32'h00000002 << to_sel; // RL8
      half    = 32'h00000001 << to_sel; // RL8
      ban     = 32'h00000001 << ban_sel;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter state machine.

   wdcs_state_t state_reg;
   wdcs_state_t state_next;
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic        late_clear;
   logic        banned_clear;

   assign late_clear   = (cnt_reg >= half);
   assign banned_clear = act.mode && (cnt_reg < ban);

   // The count advances on watchdog ticks only; a clear is seen at once so
   // that a late clear cannot slip past the boundary while waiting a tick.
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            cnt_next = 32'h00000000;
            if (act.enable) begin
               state_next = ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (!act.enable) begin
               state_next = ST_IDLE;
               cnt_next   = 32'h00000000;
            end else if (clr_wr) begin
               if (late_clear) begin
                  state_next = ST_FIRED; // RL1
               end else if (banned_clear) begin
                  state_next = ST_FIRED;
               end else begin
                  cnt_next = 32'h00000000; // RL2
               end
            end else if (wd_tick) begin
               if (cnt_reg == 32'(period - 32'h00000001)) begin
                  state_next = ST_FIRED; // RL3
               end else begin
                  cnt_next = 32'(cnt_reg + 32'h00000001);
               end
            end
         end
         ST_FIRED: begin
            state_next = ST_FIRED;
         end
         default: begin
            state_next = ST_IDLE;
            cnt_next   = 32'h00000000;
         end
      endcase
   end

   // Registers of the counter. Once fired, only the system reset leaves.
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 32'h00000000;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read path and output flops.

   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic              wd_reset_reg;
   logic              wd_reset_next;
   logic              active_reg;
   logic              active_next;

   // Enable reads back from the watchdog side, the other fields from the
   // written copy, so only enable tells software when the update took hold.
   always_comb begin
      rdata_next = '0;
      if (i_rd) begin
         case (i_addr)
            OFS_CTRL: begin
               rdata_next[CTRL_EN_BIT]               = act.enable; // RL5
               rdata_next[CTRL_MODE_BIT]             = hold.mode;
               rdata_next[CTRL_TO_LSB +: SEL_W]      = hold.timeout_prescale;
               rdata_next[CTRL_BAN_LSB +: SEL_W]     = hold.ban_prescale_select;
            end
            OFS_COUNT: begin
               rdata_next = cnt_reg;
            end
            default: begin
               rdata_next = '0;
            end
         endcase
      end
      wd_reset_next = (state_next == ST_FIRED);
      active_next   = act.enable;
   end

   // Output flops.
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rdata_reg    <= '0;
         wd_reset_reg <= 1'b0;
         active_reg   <= 1'b0;
      end else begin
         rdata_reg    <= rdata_next;
         wd_reset_reg <= wd_reset_next;
         active_reg   <= active_next;
      end
   end

   assign o_rdata    = rdata_reg;
   assign o_wd_reset = wd_reset_reg;
   assign o_active   = active_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence fire_seq;
      (state_reg == ST_FIRED) && o_wd_reset;
   endsequence

   sequence restart_seq;
      (state_reg == ST_COUNT) && (cnt_reg == 32'h00000000) && !o_wd_reset;
   endsequence

   clear_late_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL1
      (state_reg == ST_COUNT && act.enable && clr_wr && late_clear) |=> fire_seq)
      else $error("Late clear did not fire the watchdog reset at once.");

   clear_early_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL2
      (state_reg == ST_COUNT && act.enable && clr_wr && !late_clear && !banned_clear)
      |=> restart_seq)
      else $error("Early clear did not restart the count.");

   full_period_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL3
      (state_reg == ST_COUNT && !o_wd_reset) |-> (cnt_reg < period))
      else $error("Counter ran past the timeout period without firing.");

   no_early_fire_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL3
      ($past(state_reg) == ST_COUNT && state_reg == ST_FIRED && !$past(clr_wr))
      |-> ($past(cnt_reg) == 32'(period - 32'h00000001) && $past(wd_tick)))
      else $error("Watchdog fired before the full period elapsed.");

   // Counting across the half mark must enter the second half without firing.
   half_point_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL8
      (state_reg == ST_COUNT && act.enable && !clr_wr && wd_tick && !sync_busy
       && cnt_reg == 32'(half - 32'h00000001)) |=> (late_clear && state_reg == ST_COUNT))
      else $error("Half boundary does not sit at half the period.");

   en_readback_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL5
      (i_rd && i_addr == OFS_CTRL) |=> (o_rdata[CTRL_EN_BIT] == $past(act.enable)))
      else $error("Enable readback does not show the active enable.");

   // Counting cycles without a clear, split by whether the watchdog clock ticks.
   sequence quiet_seq;
      (state_reg == ST_COUNT) && act.enable && !clr_wr && !wd_tick;
   endsequence

   sequence step_seq;
      (state_reg == ST_COUNT) && act.enable && !clr_wr && wd_tick
         && (cnt_reg != 32'(period - 32'h00000001));
   endsequence

   // A control write while an update is in flight must leave the held word alone.
   ctrl_refuse_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL7
      (i_wr && i_addr == OFS_CTRL && sync_busy) |=> $stable(hold))
      else $error("Control write was taken while an update was in flight.");

   // An accepted control write starts the synchroniser with the written fields.
   ctrl_load_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL4
      (i_wr && i_addr == OFS_CTRL && !sync_busy) |=> (sync_busy && hold == $past(ctrl_new)))
      else $error("Control write did not start the synchroniser.");

   // The active flag mirrors the enable acting in the watchdog domain.
   active_mirror_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL5
      o_active == $past(act.enable))
      else $error("Active output does not follow the acting enable.");

   // Between watchdog ticks the count must not move unless a clear or a disable resets it.
   tick_only_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL8
      quiet_seq |=> $stable(cnt_reg))
      else $error("Count moved without a watchdog tick.");

   // Each watchdog tick below the last value, with no clear in the same cycle, advances the count by one.
   tick_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL8
      step_seq |=> (cnt_reg == 32'($past(cnt_reg) + 32'h00000001)))
      else $error("Count did not advance by one on a watchdog tick.");

   // Once fired, the reset request stays until the system reset.
   fired_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL1
      fire_seq |=> fire_seq)
      else $error("Watchdog reset request dropped before the system reset.");

   // A stopped watchdog holds a zero count and requests no reset.
   idle_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL3
      (state_reg == ST_IDLE) |-> (cnt_reg == 32'h00000000 && !o_wd_reset))
      else $error("Stopped watchdog shows a count or a reset request.");

   // Turning on starts a fresh count with no reset request.
   start_count_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL3
      (state_reg == ST_IDLE && act.enable) |=> restart_seq)
      else $error("Enabled watchdog did not start a fresh count.");

   // Read data stand only in the cycle after a read strobe.
   rdata_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL5
      !i_rd |=> (o_rdata == 32'h00000000))
      else $error("Read data stood outside the cycle after a read.");

   // In window mode a clear inside the ban window fires at once.
   ban_fire_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RL2
      (state_reg == ST_COUNT && act.enable && clr_wr && banned_clear) |=> fire_seq)
      else $error("Clear inside the ban window did not fire the watchdog reset.");

endmodule

// file: sim/wdcs_top_tb.sv
/*
 * Self-checking testbench of the watchdog top: control writes, enable readback,
 * clear window and timeout firing.
 * Assumes the package offsets and field positions and a watchdog tick every WD_DIV core cycles.
 */
`timescale 1ns/1ps
module wdcs_top_tb
   import wdcs_pkg::*;
;
   logic              i_core_clk;
   logic              i_rst_n;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata;
   logic              i_wr;
   logic              i_rd;
   logic [DATA_W-1:0] o_rdata;
   logic              o_wd_reset;
   logic              o_active;
   int                miscompares;
   int                checked;

   ////////////////////////////////////////////////////////////////////////////////
   // Device under test.
   wdcs_top dut_u (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_addr     (i_addr),
      .i_wdata    (i_wdata),
      .i_wr       (i_wr),
      .i_rd       (i_rd),
      .o_rdata    (o_rdata),
      .o_wd_reset (o_wd_reset),
      .o_active   (o_active)
   );

   // The clock toggles every half period of 100 ns.
   always #50 i_core_clk = ~i_core_clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, printed once at the single end of the run.
   task automatic results();
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Compares with case equality so that an unknown never matches.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One-cycle write strobe; returns at the edge that samples it.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
   endtask

   // One-cycle read strobe; the data stand only in the following cycle.
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   // Builds a control word with mode 0 and ban select 0.
   function automatic logic [31:0] mk(input logic en, input logic [4:0] to);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CTRL_EN_BIT] = en;
      w[CTRL_TO_LSB +: SEL_W] = to;
      return w;
   endfunction

   // Polls the enable readback under a bound, as software must.
   task automatic wait_en(input logic e);
      logic [31:0] d;
      d = 32'h0000_0000;
      for (int n = 0; n < 40; n++) begin
         rd(OFS_CTRL, d);
         if (d[CTRL_EN_BIT] === e) break;
      end
      chk("enable readback", {31'h0, e}, {31'h0, d[CTRL_EN_BIT]});
   endtask

   // Polls the counter until it reaches a floor; the count moves once per tick.
   task automatic wait_cnt(input logic [31:0] floor_v);
      logic [31:0] d;
      d = 32'h0000_0000;
      for (int n = 0; n < 200; n++) begin
         rd(OFS_COUNT, d);
         if (d >= floor_v) break;
      end
      chk("count floor", 32'h1, {31'h0, d >= floor_v});
   endtask

   task automatic do_reset();
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      repeat (10) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Enables with a control word; the enable bit lags while other fields do not.
   task automatic t_enable(input logic [31:0] w);
      logic [31:0] d;
      wr(OFS_CTRL, w);
      rd(OFS_CTRL, d);
      chk("ctrl during sync", {w[31:1], 1'b0}, d);
      wait_en(1'b1);
      #1;
      chk("active", 32'h1, {31'h0, o_active});
   endtask

   // Reset values and an unmapped address.
   task automatic t_reset_vals();
      logic [31:0] d;
      #1;
      chk("wd reset idle", 32'h0, {31'h0, o_wd_reset});
      chk("active idle", 32'h0, {31'h0, o_active});
      wr(4'hC, 32'hFFFF_FFFF);
      rd(4'hC, d);
      chk("unmapped", 32'h0, d);
      rd(OFS_CTRL, d);
      chk("ctrl reset", 32'h0, d);
   endtask

   // Clear in the first half, then let the full period run out.
   task automatic t_first_half_and_timeout();
      logic [31:0] d;
      t_enable(mk(1'b1, 5'h02));
      wait_cnt(32'h1);
      wr(OFS_CLEAR, 32'h0000_0001);
      rd(OFS_COUNT, d);
      chk("count after clear", 32'h1, {31'h0, d <= 32'h1});
      chk("no reset on early clear", 32'h0, {31'h0, o_wd_reset});
      // Eight ticks of ten cycles: nothing may fire within seventy cycles of the clear.
      for (int n = 0; n < 68; n++) begin
         @(posedge i_core_clk);
         #1;
         if (o_wd_reset !== 1'b0) break;
      end
      chk("no early timeout", 32'h0, {31'h0, o_wd_reset});
      for (int n = 0; n < 14; n++) begin
         @(posedge i_core_clk);
         #1;
         if (o_wd_reset === 1'b1) break;
      end
      chk("timeout fires", 32'h1, {31'h0, o_wd_reset});
      wr(OFS_CLEAR, 32'h0000_0001);
      repeat (3) @(posedge i_core_clk);
      #1;
      chk("reset sticks", 32'h1, {31'h0, o_wd_reset});
   endtask

   // Larger select moves the half mark; a late clear fires at once.
   task automatic t_second_half();
      do_reset();
      t_enable(mk(1'b1, 5'h03));
      wait_cnt(32'h5);
      wr(OFS_CLEAR, 32'h0000_0001);
      repeat (2) @(posedge i_core_clk);
      #1;
      chk("clear below new half", 32'h0, {31'h0, o_wd_reset});
      wait_cnt(32'h9);
      wr(OFS_CLEAR, 32'h0000_0001);
      repeat (2) @(posedge i_core_clk);
      #1;
      chk("late clear fires", 32'h1, {31'h0, o_wd_reset});
   endtask

   // Disable: the old enable shows until the update lands.
   task automatic t_disable();
      logic [31:0] d;
      do_reset();
      t_enable(mk(1'b1, 5'h04));
      wr(OFS_CTRL, mk(1'b0, 5'h04));
      rd(OFS_CTRL, d);
      chk("old enable kept", mk(1'b1, 5'h04), d);
      @(posedge i_core_clk);
      #1;
      chk("rdata after read", 32'h0, o_rdata);
      wait_en(1'b0);
      #1;
      chk("inactive", 32'h0, {31'h0, o_active});
      rd(OFS_COUNT, d);
      chk("count stopped", 32'h0, d);
   endtask

   // Window mode: a clear past the ban window restarts, one inside it fires.
   task automatic t_window();
      logic [31:0] w;
      do_reset();
      w = mk(1'b1, 5'h03);
      w[CTRL_MODE_BIT] = 1'b1;
      w[CTRL_BAN_LSB +: SEL_W] = 5'h02;
      t_enable(w);
      wait_cnt(32'h5);
      wr(OFS_CLEAR, 32'h0000_0001);
      repeat (2) @(posedge i_core_clk);
      #1;
      chk("clear past ban", 32'h0, {31'h0, o_wd_reset});
      wr(OFS_CLEAR, 32'h0000_0001);
      repeat (2) @(posedge i_core_clk);
      #1;
      chk("clear inside ban", 32'h1, {31'h0, o_wd_reset});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      i_core_clk  = 1'b0;
      i_rst_n     = 1'b0;
      i_addr      = 4'h0;
      i_wdata     = 32'h0000_0000;
      i_wr        = 1'b0;
      i_rd        = 1'b0;
      miscompares = 0;
      checked     = 0;
      do_reset();
      t_reset_vals();
      t_first_half_and_timeout();
      t_second_half();
      t_disable();
      t_window();
      results();
   end

   // Whole run is a few hundred cycles; this limit cuts off a hang.
   initial begin
      repeat (20000) @(posedge i_core_clk);
      miscompares++;
      results();
   end
endmodule
